// ==== verilog/phy_port_pkg.sv ====
/*
  Constants for the transceiver port control register slice: register
  offsets, field positions and reset values.
  Assumes a byte-addressed plain register port with 16-bit data.
*/
`default_nettype none

package phy_port_pkg;

  // ----------------------------------------
  // Bus widths
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] PORT_CTRL_OFS = 8'h00;
  localparam logic [7:0] BASIC_CTRL_OFS = 8'h04;
  localparam logic [7:0] LINK_STATUS_OFS = 8'h08;

  // ----------------------------------------
  // Port control fields
  // ----------------------------------------
  localparam int PC_MDIX_OFF = 10;
  localparam int PC_FORCE_MDIX = 9;
  localparam int PC_NEG_EN = 7;
  localparam int PC_SPEED = 6;
  localparam int PC_DUPLEX = 5;
  localparam int PC_PAUSE = 4;

  // ----------------------------------------
  // Basic control fields (mirrors)
  // ----------------------------------------
  localparam int BC_MDIX_OFF = 3;
  localparam int BC_FORCE_MDIX = 4;
  localparam int BC_NEG_EN = 12;
  localparam int BC_SPEED = 13;
  localparam int BC_DUPLEX = 8;

  // ----------------------------------------
  // Link status fields
  // ----------------------------------------
  localparam int LS_DONE = 0;
  localparam int LS_FAILED = 1;
  localparam int LS_SPEED = 2;
  localparam int LS_DUPLEX = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_MDIX_OFF = 1'h0;
  localparam logic RST_FORCE_MDIX = 1'h0;
  localparam logic RST_NEG_EN = 1'h1;
  localparam logic RST_SPEED = 1'h1;
  localparam logic RST_DUPLEX = 1'h1;
  localparam logic RST_PAUSE = 1'h1;

  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  localparam int SYNC_W = 4;

endpackage

`default_nettype wire

// ==== verilog/pin_sync.sv ====
/*
  Three-stage synchroniser for transceiver status pins. The output
  changes only when the second and third stages agree.
  Assumes inputs are asynchronous to clk.
*/
`default_nettype none

module pin_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins
  input wire logic [W-1:0] pinIn,
  // Filtered level
  output logic [W-1:0] pinOut
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end else begin
      s1_reg <= pinIn;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign pinOut = out_reg;

endmodule // pin_sync

`default_nettype wire

// ==== verilog/phy_port_control_bits.sv ====
/*
  Port control register slice for the integrated transceiver: crossover,
  negotiation enable, forced speed/duplex and pause advertisement, with
  mirror bits in the basic control register and a link status register.
  Assumes a plain register port on clk and negotiation status pins
  asynchronous to clk.
*/
// Decided for this implementation: the register addresses and the strobed register port.
`default_nettype none

module phy_port_control_bits
  import phy_port_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [phy_port_pkg::ADDR_W-1:0] addr,
  input wire logic [phy_port_pkg::DATA_W-1:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [phy_port_pkg::DATA_W-1:0] rdata,
  // Negotiation status pins
  input wire logic negDone,
  input wire logic negFailed,
  input wire logic negSpeed100,
  input wire logic negFullDuplex,
  // Transceiver controls
  output logic autoMdixOff,
  output logic forceMdix,
  output logic negEnable,
  output logic advertisePause,
  output logic linkSpeed100,
  output logic linkFullDuplex
);

  import phy_port_pkg::*;

  // ----------------------------------------
  // Status synchroniser
  // ----------------------------------------
  logic [SYNC_W-1:0] stat;
  logic doneS;
  logic failS;
  logic spdS;
  logic dupS;

  pin_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .pinIn({negFullDuplex, negSpeed100, negFailed, negDone}),
    .pinOut(stat)
  );

  assign doneS = stat[0];
  assign failS = stat[1];
  assign spdS = stat[2];
  assign dupS = stat[3];

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  logic mdixOff_reg, mdixOff_next;
  logic fMdix_reg, fMdix_next;
  logic negEn_reg, negEn_next;
  logic fSpeed_reg, fSpeed_next;
  logic fDuplex_reg, fDuplex_next;
  logic pause_reg, pause_next;
  logic portWr;
  logic basicWr;

  assign portWr = we && (addr == PORT_CTRL_OFS);
  assign basicWr = we && (addr == BASIC_CTRL_OFS);

  always_comb begin
    mdixOff_next = mdixOff_reg;
    fMdix_next = fMdix_reg;
    negEn_next = negEn_reg;
    fSpeed_next = fSpeed_reg;
    fDuplex_next = fDuplex_reg;
    pause_next = pause_reg;
    if (portWr) begin
      mdixOff_next = wdata[PC_MDIX_OFF];
      fMdix_next = wdata[PC_FORCE_MDIX];
      negEn_next = wdata[PC_NEG_EN];
      fSpeed_next = wdata[PC_SPEED];
      fDuplex_next = wdata[PC_DUPLEX];
      pause_next = wdata[PC_PAUSE];
    end else if (basicWr) begin
      mdixOff_next = wdata[BC_MDIX_OFF];
      fMdix_next = wdata[BC_FORCE_MDIX];
      negEn_next = wdata[BC_NEG_EN];
      fSpeed_next = wdata[BC_SPEED];
      fDuplex_next = wdata[BC_DUPLEX];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mdixOff_reg <= RST_MDIX_OFF;
      fMdix_reg <= RST_FORCE_MDIX;
      negEn_reg <= RST_NEG_EN;
      fSpeed_reg <= RST_SPEED;
      fDuplex_reg <= RST_DUPLEX;
      pause_reg <= RST_PAUSE;
    end else begin
      mdixOff_reg <= mdixOff_next;
      fMdix_reg <= fMdix_next;
      negEn_reg <= negEn_next;
      fSpeed_reg <= fSpeed_next;
      fDuplex_reg <= fDuplex_next;
      pause_reg <= pause_next;
    end
  end

  assign autoMdixOff = mdixOff_reg;
  assign forceMdix = fMdix_reg;
  assign negEnable = negEn_reg;
  assign advertisePause = pause_reg;

  // ----------------------------------------
  // Link mode resolution
  // ----------------------------------------
  logic spd_reg, spd_next;
  logic dup_reg, dup_next;

  always_comb begin
    spd_next = fSpeed_reg;
    dup_next = fDuplex_reg;
    if (negEn_reg && doneS && !failS) begin
      spd_next = spdS;
      dup_next = dupS;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      spd_reg <= RST_SPEED;
      dup_reg <= RST_DUPLEX;
    end else begin
      spd_reg <= spd_next;
      dup_reg <= dup_next;
    end
  end

  assign linkSpeed100 = spd_reg;
  assign linkFullDuplex = dup_reg;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [DATA_W-1:0] rd_reg, rd_next;

  function automatic logic [DATA_W-1:0] readMux(
    input logic [ADDR_W-1:0] a
  );
    logic [DATA_W-1:0] v;
    v = '0;
    case (a)
      PORT_CTRL_OFS: begin
        v[PC_MDIX_OFF] = mdixOff_reg;
        v[PC_FORCE_MDIX] = fMdix_reg;
        v[PC_NEG_EN] = negEn_reg;
        v[PC_SPEED] = fSpeed_reg;
        v[PC_DUPLEX] = fDuplex_reg;
        v[PC_PAUSE] = pause_reg;
      end
      BASIC_CTRL_OFS: begin
        v[BC_MDIX_OFF] = mdixOff_reg;
        v[BC_FORCE_MDIX] = fMdix_reg;
        v[BC_NEG_EN] = negEn_reg;
        v[BC_SPEED] = fSpeed_reg;
        v[BC_DUPLEX] = fDuplex_reg;
      end
      LINK_STATUS_OFS: begin
        v[LS_DONE] = doneS;
        v[LS_FAILED] = failS;
        v[LS_SPEED] = spd_reg;
        v[LS_DUPLEX] = dup_reg;
      end
      default: begin
        v = '0;
      end
    endcase
    return v;
  endfunction

  always_comb begin
    rd_next = '0;
    if (re) begin
      rd_next = readMux(addr);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign rdata = rd_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic lastBasicMdix_reg, lastBasicMdix_next;

  always_comb begin
    lastBasicMdix_next = lastBasicMdix_reg;
    if (basicWr) begin
      lastBasicMdix_next = wdata[BC_MDIX_OFF];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lastBasicMdix_reg <= 1'h0;
    end else begin
      lastBasicMdix_reg <= lastBasicMdix_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_basicWrite;
    we && !re && (addr == BASIC_CTRL_OFS);
  endsequence

  sequence s_portRead;
    re && !we && (addr == PORT_CTRL_OFS);
  endsequence

  a_mdix_off_write: assert property (
    portWr |=> autoMdixOff == $past(wdata[PC_MDIX_OFF]))
    else $error("crossover disable bit not written");

  a_force_mdix_write: assert property (
    portWr |=> forceMdix == $past(wdata[PC_FORCE_MDIX]))
    else $error("force crossed bit not written");

  a_forced_speed: assert property (
    !negEn_reg |=> linkSpeed100 == $past(fSpeed_reg))
    else $error("forced speed not applied");

  a_neg_result: assert property (
    (negEn_reg && doneS && !failS) |=> linkSpeed100 == $past(spdS))
    else $error("negotiated speed not applied");

  a_failed_duplex: assert property (
    (negEn_reg && failS) |=> linkFullDuplex == $past(fDuplex_reg))
    else $error("forced duplex not applied on failure");

  a_pause_adv: assert property (
    portWr |=> advertisePause == $past(wdata[PC_PAUSE]))
    else $error("pause advertisement not written");

  a_mirror_read: assert property (
    s_basicWrite ##1 s_portRead |=> rdata[PC_MDIX_OFF] == lastBasicMdix_reg)
    else $error("mirror bit not coherent");

endmodule // phy_port_control_bits

`default_nettype wire

// ==== tb/phy_port_control_bits_tb.sv ====
/*
  Self-checking bench for the port control register slice.
  Assumes the plain register port and status pins of the design top.
*/
`default_nettype none

module phy_port_control_bits_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import phy_port_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic negDone = 1'b0;
  logic negFailed = 1'b0;
  logic negSpeed100 = 1'b0;
  logic negFullDuplex = 1'b0;
  logic autoMdixOff, forceMdix, negEnable, advertisePause;
  logic linkSpeed100, linkFullDuplex;
  int num_errors = 0;
  int checks = 0;
  logic [DATA_W-1:0] d;

  always #4 clk = ~clk;

  phy_port_control_bits i_phy_port_control_bits (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata(rdata), .negDone(negDone), .negFailed(negFailed),
    .negSpeed100(negSpeed100), .negFullDuplex(negFullDuplex),
    .autoMdixOff(autoMdixOff), .forceMdix(forceMdix),
    .negEnable(negEnable), .advertisePause(advertisePause),
    .linkSpeed100(linkSpeed100), .linkFullDuplex(linkFullDuplex)
  );

  // ----------------------------------------
  // Bus tasks and compares
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    we <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] wa, input logic [15:0] wv,
    input logic [7:0] ra, output logic [15:0] v);
    @(posedge clk);
    we <= 1'b1;
    addr <= wa;
    wdata <= wv;
    @(posedge clk);
    we <= 1'b0;
    re <= 1'b1;
    addr <= ra;
    @(posedge clk);
    re <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_outs(input logic [5:0] exp);
    cmp_word({10'h000, autoMdixOff, forceMdix, negEnable, advertisePause,
      linkSpeed100, linkFullDuplex}, {10'h000, exp});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #20000;
    num_errors++;
    report_and_stop();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    cmp_outs(6'b001111);
    rd(PORT_CTRL_OFS, d);
    cmp_word(d, 16'h00f0);
    rd(BASIC_CTRL_OFS, d);
    cmp_word(d, 16'h3100);
    $display("test reset done");

    wr(PORT_CTRL_OFS, 16'h0600);
    settle(2);
    cmp_outs(6'b110000);
    rd(BASIC_CTRL_OFS, d);
    cmp_word(d, 16'h0018);
    rd(PORT_CTRL_OFS, d);
    cmp_word(d, 16'h0600);
    $display("test forced slow done");

    wr(BASIC_CTRL_OFS, 16'h2100);
    settle(2);
    cmp_outs(6'b000011);
    rd(PORT_CTRL_OFS, d);
    cmp_word(d, 16'h0060);
    wr(PORT_CTRL_OFS, 16'h0210);
    settle(2);
    cmp_outs(6'b010100);
    $display("test mirror done");

    wr(PORT_CTRL_OFS, 16'h00f0);
    @(posedge clk);
    negDone <= 1'b1;
    negSpeed100 <= 1'b0;
    negFullDuplex <= 1'b0;
    settle(10);
    cmp_outs(6'b001100);
    rd(LINK_STATUS_OFS, d);
    cmp_word(d, 16'h0001);
    @(posedge clk);
    negFailed <= 1'b1;
    settle(10);
    cmp_outs(6'b001111);
    wr(PORT_CTRL_OFS, 16'h00c0);
    settle(2);
    cmp_outs(6'b001010);
    $display("test negotiation done");

    wr(PORT_CTRL_OFS, 16'h0080);
    settle(2);
    cmp_outs(6'b001000);
    wr(PORT_CTRL_OFS, 16'h0010);
    settle(2);
    cmp_outs(6'b000100);
    rd(8'h0c, d);
    cmp_word(d, 16'h0000);
    settle(1);
    cmp_word(rdata, 16'h0000);
    $display("test pause and unmapped done");

    wr_rd(BASIC_CTRL_OFS, 16'h0008, PORT_CTRL_OFS, d);
    cmp_word(d, 16'h0410);
    wr_rd(PORT_CTRL_OFS, 16'h0200, BASIC_CTRL_OFS, d);
    cmp_word(d, 16'h0010);
    $display("test back to back done");

    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    cmp_outs(6'b001111);
    rd(PORT_CTRL_OFS, d);
    cmp_word(d, 16'h00f0);
    $display("test second reset done");
    report_and_stop();
  end

endmodule // phy_port_control_bits_tb

`default_nettype wire
